//--- verilog/reset_init_pkg.sv
// Shared constants, register layout and reset-value table for the reset state initializer
package reset_init_pkg;

	// Register port geometry
	localparam int ADDR_W = 6;
	localparam int DATA_W = 8;
	localparam int REG_COUNT = 47;

	// Register indices that need their own logic
	localparam logic [ADDR_W-1:0] IDX_PROGRAM_COUNTER_LOW = 6'h02;
	localparam logic [ADDR_W-1:0] IDX_CORE_STATUS = 6'h03;
	localparam logic [ADDR_W-1:0] IDX_PROGRAM_COUNTER_HIGH_LATCH = 6'h0a;
	localparam logic [ADDR_W-1:0] IDX_INTERRUPT_CONTROL = 6'h0b;
	localparam logic [ADDR_W-1:0] IDX_PERIPHERAL_FLAGS_ONE = 6'h0c;
	localparam logic [ADDR_W-1:0] IDX_PERIPHERAL_FLAGS_TWO = 6'h0d;
	localparam logic [ADDR_W-1:0] IDX_POWER_RESET_CAUSE = 6'h28;

	// Core status fields
	localparam int STATUS_EXPIRY_BIT = 4;
	localparam int STATUS_SLEEP_BIT = 3;
	localparam logic [7:0] STATUS_BANK_MASK = 8'he0;
	localparam logic [7:0] STATUS_WRITE_MASK = 8'he7;
	localparam logic [7:0] STATUS_LOW_MASK = 8'h07;

	// Power reset cause fields
	localparam int CAUSE_POWER_ON_BIT = 1;
	localparam int CAUSE_LOW_SUPPLY_BIT = 0;
	localparam logic [7:0] CAUSE_IMPL_MASK = 8'h03;

	// Interrupt control fields and program counter layout
	localparam int GLOBAL_INTERRUPT_ENABLE_BIT = 7;
	localparam int PC_FULL_W = 13;
	localparam int PROGRAM_COUNTER_HIGH_LATCH_W = 5;
	localparam logic [PC_FULL_W-1:0] RESET_VECTOR = 13'h0000;
	localparam logic [PC_FULL_W-1:0] INTERRUPT_VECTOR = 13'h0004;

	// Reset conditions as delivered by the reset detection circuitry
	typedef struct packed {
		logic power_on;
		logic brown_out;
		logic pin_run;
		logic pin_sleep;
		logic watchdog_reset;
		logic watchdog_wake;
		logic interrupt_wake;
	} cond_t;

	// Flag bits of the source that caused a wake-up
	typedef struct packed {
		logic [7:0] interrupt_control;
		logic [7:0] peripheral_flags_one;
		logic [7:0] peripheral_flags_two;
	} wake_src_t;

	// Winning cause after priority
	typedef enum logic [2:0] {
		CAUSE_NONE = 3'b000,
		CAUSE_POWER_ON = 3'b001,
		CAUSE_BROWN_OUT = 3'b010,
		CAUSE_WATCHDOG_RESET = 3'b011,
		CAUSE_PIN_SLEEP = 3'b100,
		CAUSE_PIN_RUN = 3'b101,
		CAUSE_WATCHDOG_WAKE = 3'b110,
		CAUSE_INTERRUPT_WAKE = 3'b111
	} cause_t;

	// Group of reset values that a plain register follows
	typedef enum logic [1:0] {
		CLS_NONE = 2'b00,
		CLS_POWER = 2'b01,
		CLS_RESET = 2'b10,
		CLS_WAKE = 2'b11
	} cond_class_t;

	// Sequencer states
	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_HOLD = 2'b01,
		ST_RELEASE = 2'b10
	} seq_state_t;

	// Per-register reset description; keep bits retain their value
	typedef struct packed {
		logic own;
		logic [7:0] impl;
		logic [7:0] por_val;
		logic [7:0] por_keep;
		logic [7:0] rst_val;
		logic [7:0] rst_keep;
		logic wake_load;
		logic [7:0] wake_val;
	} reg_desc_t;

	localparam reg_desc_t REG_TABLE [REG_COUNT] = '{
		'{1'b0, 8'hff, 8'h00, 8'hff, 8'h00, 8'hff, 1'b0, 8'h00}, // accumulator
		'{1'b0, 8'hff, 8'h00, 8'hff, 8'h00, 8'hff, 1'b0, 8'h00}, // eight_bit_free_counter
		'{1'b1, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00}, // program_counter_low
		'{1'b1, 8'hff, 8'h18, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00}, // core_status
		'{1'b0, 8'hff, 8'h00, 8'hff, 8'h00, 8'hff, 1'b0, 8'h00}, // indirect_pointer
		'{1'b0, 8'h3f, 8'h00, 8'h10, 8'h00, 8'h10, 1'b0, 8'h00}, // port_a_data
		'{1'b0, 8'hff, 8'h00, 8'hff, 8'h00, 8'hff, 1'b0, 8'h00}, // port_b_data
		'{1'b0, 8'hff, 8'h00, 8'hff, 8'h00, 8'hff, 1'b0, 8'h00}, // port_c_data
		'{1'b0, 8'hff, 8'h00, 8'hff, 8'h00, 8'hff, 1'b0, 8'h00}, // port_d_data
		'{1'b0, 8'h07, 8'h00, 8'h07, 8'h00, 8'h07, 1'b0, 8'h00}, // port_e_data
		'{1'b0, 8'h1f, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00}, // program_counter_high_latch
		'{1'b0, 8'hff, 8'h00, 8'h01, 8'h00, 8'h01, 1'b0, 8'h00}, // interrupt_control
		'{1'b0, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00}, // peripheral_flags_one
		'{1'b0, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00}, // peripheral_flags_two
		'{1'b0, 8'hff, 8'h00, 8'hff, 8'h00, 8'hff, 1'b0, 8'h00}, // wide_timer_low
		'{1'b0, 8'hff, 8'h00, 8'hff, 8'h00, 8'hff, 1'b0, 8'h00}, // wide_timer_high
		'{1'b0, 8'h3f, 8'h00, 8'h00, 8'h00, 8'h3f, 1'b0, 8'h00}, // wide_timer_control
		'{1'b0, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00}, // period_matched_count
		'{1'b0, 8'h7f, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00}, // period_timer_control
		'{1'b0, 8'hff, 8'h00, 8'hff, 8'h00, 8'hff, 1'b0, 8'h00}, // sync_serial_buffer
		'{1'b0, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00}, // sync_serial_control
		'{1'b0, 8'hff, 8'h00, 8'hff, 8'h00, 8'hff, 1'b0, 8'h00}, // capture_one_low
		'{1'b0, 8'hff, 8'h00, 8'hff, 8'h00, 8'hff, 1'b0, 8'h00}, // capture_one_high
		'{1'b0, 8'h3f, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00}, // capture_unit_one_control
		'{1'b0, 8'hf7, 8'h00, 8'h01, 8'h00, 8'h01, 1'b0, 8'h00}, // serial_receive_status
		'{1'b0, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00}, // serial_transmit_buffer
		'{1'b0, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00}, // serial_receive_buffer
		'{1'b0, 8'hff, 8'h00, 8'hff, 8'h00, 8'hff, 1'b0, 8'h00}, // capture_two_low
		'{1'b0, 8'hff, 8'h00, 8'hff, 8'h00, 8'hff, 1'b0, 8'h00}, // capture_two_high
		'{1'b0, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00}, // capture_unit_two_control
		'{1'b0, 8'hff, 8'h00, 8'hff, 8'h00, 8'hff, 1'b0, 8'h00}, // conversion_result
		'{1'b0, 8'hfd, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00}, // converter_control_zero
		'{1'b0, 8'hff, 8'hff, 8'h00, 8'hff, 8'h00, 1'b0, 8'h00}, // option_config
		'{1'b0, 8'h3f, 8'h3f, 8'h00, 8'h3f, 8'h00, 1'b0, 8'h00}, // port_a_direction
		'{1'b0, 8'hff, 8'hff, 8'h00, 8'hff, 8'h00, 1'b0, 8'h00}, // port_b_direction
		'{1'b0, 8'hff, 8'hff, 8'h00, 8'hff, 8'h00, 1'b0, 8'h00}, // port_c_direction
		'{1'b0, 8'hff, 8'hff, 8'h00, 8'hff, 8'h00, 1'b0, 8'h00}, // port_d_direction
		'{1'b0, 8'hf7, 8'h07, 8'h00, 8'h07, 8'h00, 1'b0, 8'h00}, // port_e_direction
		'{1'b0, 8'hbf, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00}, // peripheral_enables_one
		'{1'b0, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00}, // peripheral_enables_two
		'{1'b1, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00}, // power_reset_cause
		'{1'b0, 8'hff, 8'hff, 8'h00, 8'hff, 8'h00, 1'b1, 8'hff}, // timer_period_limit
		'{1'b0, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00}, // sync_serial_address
		'{1'b0, 8'h3f, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00}, // sync_serial_state
		'{1'b0, 8'hf7, 8'h02, 8'h00, 8'h02, 8'h00, 1'b0, 8'h00}, // serial_transmit_status
		'{1'b0, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00}, // baud_divisor
		'{1'b0, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00}  // converter_control_one
	};

endpackage

//--- verilog/reset_cell.sv
// One special function register that follows its reset-value description
`timescale 1ns/1ns
module reset_cell import reset_init_pkg::*; #(
	parameter reg_desc_t DESC = '0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Active reset group
	input wire cond_class_t cond_class,
	// Software access and wake flags
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	input wire logic [7:0] set_bits,
	// Current contents
	output logic [7:0] value
);

	logic [7:0] next_value;

	// Refuse descriptions whose reset value touches unimplemented bits
	if ((DESC.por_val & ~DESC.impl) != 8'h00 || (DESC.rst_val & ~DESC.impl) != 8'h00) begin : bad_desc
		$error("reset_cell: reset value outside implemented bits");
	end

	// Unknown bits simply keep whatever the flip-flop holds
	always_comb begin
		next_value = value;
		case (cond_class)
			CLS_POWER: next_value = (value & DESC.por_keep) | (DESC.por_val & ~DESC.por_keep);
			CLS_RESET: next_value = (value & DESC.rst_keep) | (DESC.rst_val & ~DESC.rst_keep);
			CLS_WAKE: begin
				if (DESC.wake_load) begin
					next_value = DESC.wake_val;
				end
			end
			default: begin
				if (wr_en) begin
					next_value = wr_data;
				end
			end
		endcase
		// Wake source flags win over anything else in the same cycle
		next_value = (next_value | set_bits) & DESC.impl;
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			value <= DESC.por_val & DESC.impl;
		end else begin
			value <= next_value;
		end
	end

endmodule

//--- verilog/reset_state_initializer.sv
// Reset state initializer: loads special function register reset values per reset cause
//
// Behaviour
// - Resets zero the start address; wakes resume after sleep
// - Interrupt wake with global enable jumps to vector
// - Core status follows the cause of reset
// - Wake keeps interrupt flags, sets wake source bits
// - Interrupt control clears upper seven bits on reset
// - Option register all ones, kept on wake
// - Port directions set to inputs on resets
// - Timer period limit all ones on every condition
// - Period timer count and control cleared, kept on wake
// - Port A data bits 0-3 and 5 cleared, bit 4 kept
// - High latch cleared on resets, kept on wake
// - First peripheral flags and enables cleared on resets
// - Wide timer control cleared only at power-on and brown-out
// - Both capture unit controls cleared on resets
// - Serial receive/transmit registers take their reset values
// - Sync serial control, state, address cleared on resets
// - Converter controls cleared; result left unknown
// - Data-holding registers except the serial transmit/receive buffers keep contents through resets
// - Unimplemented bits always read as zero
// - Expiry and sleep flags encode watchdog or pin cause
`timescale 1ns/1ns
module reset_state_initializer import reset_init_pkg::*; #(
	parameter int PC_WIDTH = PC_FULL_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Reset conditions from the detection circuitry
	input wire cond_t cond,
	input wire wake_src_t wake_src,
	input wire logic [PC_WIDTH-1:0] sleep_pc,
	// Register port
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [DATA_W-1:0] rdata,
	// Core side
	output logic [PC_WIDTH-1:0] start_address,
	output logic start_load,
	output logic core_held,
	output logic [REG_COUNT-1:0][DATA_W-1:0] sfr_image
);

	// Elaboration checks on the program counter width
	if (PC_WIDTH < 9 || PC_WIDTH > PC_FULL_W) begin : bad_pc_width
		$error("reset_state_initializer: PC_WIDTH must lie between 9 and 13");
	end

	logic [DATA_W-1:0] sfr [REG_COUNT];
	cause_t cause;
	cond_class_t cond_class;
	seq_state_t state;
	seq_state_t next_state;
	logic [DATA_W-1:0] core_status;
	logic [DATA_W-1:0] next_core_status;
	logic [DATA_W-1:0] power_reset_cause;
	logic [DATA_W-1:0] next_power_reset_cause;
	logic [PC_WIDTH-1:0] next_start_address;
	logic next_start_load;
	logic [DATA_W-1:0] next_rdata;
	logic sw_write;
	logic global_enable;
	logic [PC_FULL_W-1:0] jump_target;

	// Priority among simultaneous conditions: power loss outranks the rest
	always_comb begin
		if (cond.power_on) begin
			cause = CAUSE_POWER_ON;
		end else if (cond.brown_out) begin
			cause = CAUSE_BROWN_OUT;
		end else if (cond.watchdog_reset) begin
			cause = CAUSE_WATCHDOG_RESET;
		end else if (cond.pin_sleep) begin
			cause = CAUSE_PIN_SLEEP;
		end else if (cond.pin_run) begin
			cause = CAUSE_PIN_RUN;
		end else if (cond.watchdog_wake) begin
			cause = CAUSE_WATCHDOG_WAKE;
		end else if (cond.interrupt_wake) begin
			cause = CAUSE_INTERRUPT_WAKE;
		end else begin
			cause = CAUSE_NONE;
		end
	end

	// Group the cause into the three reset-value columns
	always_comb begin
		case (cause)
			CAUSE_POWER_ON, CAUSE_BROWN_OUT: cond_class = CLS_POWER;
			CAUSE_WATCHDOG_RESET, CAUSE_PIN_SLEEP, CAUSE_PIN_RUN: cond_class = CLS_RESET;
			CAUSE_WATCHDOG_WAKE, CAUSE_INTERRUPT_WAKE: cond_class = CLS_WAKE;
			default: cond_class = CLS_NONE;
		endcase
	end

	// Software writes only land while no condition is present
	assign sw_write = wr && (cond_class == CLS_NONE);
	assign global_enable = sfr[IDX_INTERRUPT_CONTROL][GLOBAL_INTERRUPT_ENABLE_BIT];
	assign jump_target = {sfr[IDX_PROGRAM_COUNTER_HIGH_LATCH][PROGRAM_COUNTER_HIGH_LATCH_W-1:0], wdata};

	// Plain registers, one cell each; the cell table sets every reset column
	for (genvar g = 0; g < REG_COUNT; g++) begin : cells
		if (!REG_TABLE[g].own) begin : plain
			logic [DATA_W-1:0] set_bits;
			// Only the interrupt flag registers collect wake source bits
			assign set_bits = (cond_class != CLS_WAKE) ? 8'h00 :
				(g == IDX_INTERRUPT_CONTROL) ? wake_src.interrupt_control :
				(g == IDX_PERIPHERAL_FLAGS_ONE) ? wake_src.peripheral_flags_one :
				(g == IDX_PERIPHERAL_FLAGS_TWO) ? wake_src.peripheral_flags_two : 8'h00;
			// Table
			// and
			reset_cell #(
				.DESC(REG_TABLE[g])
			) u_cell (
				.clk(clk),
				.rst_n(rst_n),
				.cond_class(cond_class),
				.wr_en(sw_write && (addr == ADDR_W'(g))),
				.wr_data(wdata),
				.set_bits(set_bits),
				.value(sfr[g])
			);
		end
	end

	// Registers with their own reset behaviour
	assign sfr[IDX_CORE_STATUS] = core_status;
	assign sfr[IDX_POWER_RESET_CAUSE] = power_reset_cause;
	assign sfr[IDX_PROGRAM_COUNTER_LOW] = start_address[DATA_W-1:0];

	// Core status: bank bits, expiry and sleep flags depend on the cause
	always_comb begin
		next_core_status = core_status;
		case (cause)
			CAUSE_POWER_ON, CAUSE_BROWN_OUT: begin
				next_core_status = (core_status & STATUS_LOW_MASK) | REG_TABLE[IDX_CORE_STATUS].por_val;
			end
			CAUSE_PIN_RUN: begin
				next_core_status = core_status & ~STATUS_BANK_MASK;
			end
			CAUSE_PIN_SLEEP: begin
				next_core_status = core_status & ~STATUS_BANK_MASK;
				next_core_status[STATUS_EXPIRY_BIT] = 1'b1;
				next_core_status[STATUS_SLEEP_BIT] = 1'b0;
			end
			CAUSE_WATCHDOG_RESET: begin
				next_core_status = core_status & ~STATUS_BANK_MASK;
				next_core_status[STATUS_EXPIRY_BIT] = 1'b0;
				next_core_status[STATUS_SLEEP_BIT] = 1'b1;
			end
			CAUSE_WATCHDOG_WAKE: begin
				next_core_status[STATUS_EXPIRY_BIT] = 1'b0;
				next_core_status[STATUS_SLEEP_BIT] = 1'b0;
			end
			CAUSE_INTERRUPT_WAKE: begin
				next_core_status[STATUS_EXPIRY_BIT] = 1'b1;
				next_core_status[STATUS_SLEEP_BIT] = 1'b0;
			end
			default: begin
				// The two flags are read-only to software
				if (sw_write && addr == IDX_CORE_STATUS) begin
					next_core_status = (wdata & STATUS_WRITE_MASK) | (core_status & ~STATUS_WRITE_MASK);
				end
			end
		endcase
	end

	// Power reset cause: power-on and low-supply indicators, software sets them
	always_comb begin
		next_power_reset_cause = power_reset_cause;
		case (cause)
			CAUSE_POWER_ON: next_power_reset_cause[CAUSE_POWER_ON_BIT] = 1'b0;
			CAUSE_BROWN_OUT: next_power_reset_cause[CAUSE_LOW_SUPPLY_BIT] = 1'b0;
			CAUSE_NONE: begin
				if (sw_write && addr == IDX_POWER_RESET_CAUSE) begin
					next_power_reset_cause = wdata & CAUSE_IMPL_MASK;
				end
			end
			default: next_power_reset_cause = power_reset_cause;
		endcase
		next_power_reset_cause = next_power_reset_cause & CAUSE_IMPL_MASK;
	end

	// Sequencer: hold while a condition stands, then release the core once
	always_comb begin
		next_state = state;
		case (state)
			ST_RUN: begin
				if (cond_class != CLS_NONE) begin
					next_state = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (cond_class == CLS_NONE) begin
					next_state = ST_RELEASE;
				end
			end
			ST_RELEASE: begin
				next_state = (cond_class != CLS_NONE) ? ST_HOLD : ST_RUN;
			end
			default: next_state = ST_HOLD;
		endcase
	end

	// Start address: vector on reset, resume after sleep, or a software jump
	always_comb begin
		next_start_address = start_address;
		next_start_load = 1'b0;
		case (cond_class)
			CLS_POWER, CLS_RESET: begin
				next_start_address = RESET_VECTOR[PC_WIDTH-1:0];
			end
			CLS_WAKE: begin
				if (cause == CAUSE_INTERRUPT_WAKE && global_enable) begin
					next_start_address = INTERRUPT_VECTOR[PC_WIDTH-1:0];
				end else begin
					next_start_address = sleep_pc + PC_WIDTH'(1);
				end
			end
			default: begin
				// Writing the low byte jumps through the high latch
				if (sw_write && addr == IDX_PROGRAM_COUNTER_LOW) begin
					next_start_address = jump_target[PC_WIDTH-1:0];
					next_start_load = 1'b1;
				end
			end
		endcase
		// The core restarts one cycle after the condition drops
		if (state == ST_HOLD && cond_class == CLS_NONE) begin
			next_start_load = 1'b1;
		end
	end

	// Read data: one cycle after the strobe; unmapped addresses give zero
	always_comb begin
		next_rdata = 8'h00;
		if (rd && addr < ADDR_W'(REG_COUNT)) begin
			next_rdata = sfr[addr];
		end
	end

	// Registers of the sequencer and special registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_HOLD;
			core_status <= REG_TABLE[IDX_CORE_STATUS].por_val;
			power_reset_cause <= 8'h00;
			start_address <= '0;
			start_load <= 1'b0;
			rdata <= 8'h00;
		end else begin
			state <= next_state;
			core_status <= next_core_status;
			power_reset_cause <= next_power_reset_cause;
			start_address <= next_start_address;
			start_load <= next_start_load;
			rdata <= next_rdata;
		end
	end

	// Core is held only in the hold state; it is already free in the release cycle
	assign core_held = (state == ST_HOLD);

	// Register image for the peripherals, straight from the flip-flops
	for (genvar i = 0; i < REG_COUNT; i++) begin : image
		assign sfr_image[i] = sfr[i];
	end

endmodule

//--- test/reset_init_checker.sv
// Port-level assertions for the reset state initializer
`timescale 1ns/1ns
module reset_init_checker import reset_init_pkg::*; #(
	parameter int PC_WIDTH = PC_FULL_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Conditions and register port
	input wire cond_t cond,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic rd,
	// Observed outputs
	input wire logic [DATA_W-1:0] rdata,
	input wire logic [PC_WIDTH-1:0] start_address,
	input wire logic start_load,
	input wire logic core_held,
	input wire logic [REG_COUNT-1:0][DATA_W-1:0] sfr_image
);
	logic [6:0] cbits;
	logic [DATA_W-1:0] next_rd_exp;
	logic [DATA_W-1:0] rd_exp;

	// Conditions as plain bits, power-on at the top
	assign cbits = cond;

	// Byte a read must return; unmapped places give zero
	always_comb begin
		next_rd_exp = (int'(addr) < REG_COUNT) ? sfr_image[addr] : 8'h00;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_exp <= 8'h00;
		end else begin
			rd_exp <= next_rd_exp;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_reset_cause;
		cbits[6:2] != 5'b00000;
	endsequence
	sequence s_wake_only;
		cbits[6:2] == 5'b00000 && cbits[1:0] != 2'b00;
	endsequence
	// Restart pulse lasts one cycle and frees the core at once
	sequence s_release_pulse;
		start_load && !core_held ##1 !start_load;
	endsequence

	property p_read_data;
		rd |=> rdata == rd_exp;
	endproperty
	property p_rdata_idle;
		!rd |=> rdata == 8'h00;
	endproperty
	property p_reset_start;
		s_reset_cause |=> start_address == 0;
	endproperty
	property p_int_vector;
		cbits == 7'h01 && sfr_image[11][7] |=> start_address == 4;
	endproperty
	property p_power_status;
		cbits[6] |=> sfr_image[3][7:3] == 5'b00011;
	endproperty
	property p_watchdog_flags;
		cbits[6:2] == 5'b00001 |=> sfr_image[3][4:3] == 2'b01;
	endproperty
	property p_pin_sleep_flags;
		cbits[6:2] == 5'b00010 |=> sfr_image[3][4:3] == 2'b10;
	endproperty
	property p_limit_ones;
		cbits != 7'h00 |=> sfr_image[41] == 8'hff;
	endproperty
	property p_option_kept;
		s_wake_only |=> $stable(sfr_image[32]);
	endproperty
	property p_wide_kept;
		cbits[6:5] == 2'b00 && cbits != 7'h00 |=> $stable(sfr_image[16]);
	endproperty
	property p_latch_cleared;
		s_reset_cause |=> sfr_image[10] == 8'h00;
	endproperty
	property p_held;
		cbits != 7'h00 |=> core_held;
	endproperty
	property p_release;
		cbits == 7'h00 && $past(cbits) != 7'h00 |=> s_release_pulse;
	endproperty

	a_read_data: assert property (p_read_data) else $error("read data wrong");
	a_rdata_idle: assert property (p_rdata_idle) else $error("rdata not zero");
	a_reset_start: assert property (p_reset_start) else $error("start not zero");
	a_int_vector: assert property (p_int_vector) else $error("no vector jump");
	a_power_status: assert property (p_power_status) else $error("status bad");
	a_watchdog_flags: assert property (p_watchdog_flags) else $error("flags bad");
	a_pin_sleep_flags: assert property (p_pin_sleep_flags) else $error("flags bad");
	a_limit_ones: assert property (p_limit_ones) else $error("limit not ones");
	a_option_kept: assert property (p_option_kept) else $error("option lost");
	a_wide_kept: assert property (p_wide_kept) else $error("timer ctl lost");
	a_latch_cleared: assert property (p_latch_cleared) else $error("latch kept");
	a_held: assert property (p_held) else $error("core not held");
	a_release: assert property (p_release) else $error("no restart pulse");
endmodule

bind reset_state_initializer reset_init_checker #(.PC_WIDTH(PC_WIDTH)) reset_init_checker_inst (
	.clk(clk),
	.rst_n(rst_n),
	.cond(cond),
	.addr(addr),
	.rd(rd),
	.rdata(rdata),
	.start_address(start_address),
	.start_load(start_load),
	.core_held(core_held),
	.sfr_image(sfr_image)
);

//--- test/reset_state_initializer_test.sv
// Self-checking bench for the reset state initializer
`timescale 1ns/1ns
module reset_state_initializer_test import reset_init_pkg::*; ;
	logic clk;
	logic rst_n;
	cond_t cond;
	wake_src_t wake_src;
	logic [12:0] sleep_pc;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic wr;
	logic rd;
	logic [DATA_W-1:0] rdata;
	logic [12:0] start_address;
	logic start_load;
	logic core_held;
	logic [REG_COUNT-1:0][DATA_W-1:0] sfr_image;
	logic [7:0] m [REG_COUNT];
	int miscompares = 0;
	int checked = 0;

	reset_state_initializer reset_state_initializer_inst (
		.clk(clk),
		.rst_n(rst_n),
		.cond(cond),
		.wake_src(wake_src),
		.sleep_pc(sleep_pc),
		.addr(addr),
		.wdata(wdata),
		.wr(wr),
		.rd(rd),
		.rdata(rdata),
		.start_address(start_address),
		.start_load(start_load),
		.core_held(core_held),
		.sfr_image(sfr_image)
	);

	// Writable bits of each register; status flags are masked separately
	function automatic logic [7:0] impl_of(int i);
		case (i)
			3: return 8'he7;
			5, 16, 23, 33, 43: return 8'h3f;
			9, 46: return 8'h07;
			10: return 8'h1f;
			13, 39: return 8'h01;
			18: return 8'h7f;
			24, 37, 44: return 8'hf7;
			31: return 8'hfd;
			38: return 8'hbf;
			40: return 8'h03;
			default: return 8'hff;
		endcase
	endfunction

	// Model value after cause c: 0 power, 1 brown, 2 pin, 3 pin sleep, 4 watchdog, 5/6 wakes
	function automatic logic [7:0] after_cond(int i, logic [7:0] v, int c, wake_src_t ws);
		logic w;
		w = c > 4;
		case (i)
			0, 1, 2, 4, 6, 7, 8, 9, 14, 15, 19, 21, 22, 27, 28, 30: return v;
			3: begin
				case (c)
					0, 1: return (v & 8'h07) | 8'h18;
					2: return v & 8'h1f;
					3: return (v & 8'h07) | 8'h10;
					4: return (v & 8'h07) | 8'h08;
					5: return v & 8'he7;
					default: return (v & 8'he7) | 8'h10;
				endcase
			end
			5: return w ? v : v & 8'h10;
			11: return w ? v | ws.interrupt_control : v & 8'h01;
			12: return w ? v | ws.peripheral_flags_one : 8'h00;
			13: return w ? v | (ws.peripheral_flags_two & 8'h01) : 8'h00;
			16: return c < 2 ? 8'h00 : v;
			24: return w ? v : v & 8'h01;
			32, 34, 35, 36: return w ? v : 8'hff;
			33: return w ? v : 8'h3f;
			37: return w ? v : 8'h07;
			40: return c == 0 ? v & 8'h01 : (c == 1 ? v & 8'h02 : v);
			41: return 8'hff;
			44: return w ? v : 8'h02;
			default: return w ? v : 8'h00;
		endcase
	endfunction

	task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Leaves the strobe up so a following access runs back to back
	task automatic wr_reg(int a, logic [7:0] d);
		wr <= 1'b1;
		rd <= 1'b0;
		addr <= a[5:0];
		wdata <= d;
		if (a < REG_COUNT) begin
			m[a] = (d & impl_of(a)) | (a == 3 ? m[3] & 8'h18 : 8'h00);
		end
		@(posedge clk);
	endtask

	task automatic rd_chk(int a);
		wr <= 1'b0;
		rd <= 1'b1;
		addr <= a[5:0];
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		check("rdata", rdata, a < REG_COUNT ? m[a] : 8'h00);
		@(posedge clk);
	endtask

	// Program counter low is left out: it follows the core, not a fixed value
	task automatic check_image();
		for (int i = 0; i < REG_COUNT; i++) begin
			if (i != 2) check("image", sfr_image[i], m[i]);
		end
	endtask

	task automatic finish_test();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Hang guard
	initial begin
		#400000;
		miscompares++;
		finish_test();
	end

	// Main sequence: sweep registers, then apply every cause in turn
	initial begin
		int c;
		logic [7:0] d;
		logic [12:0] exp_pc;
		rst_n = 1'b0;
		cond = '0;
		wake_src = '0;
		sleep_pc = '0;
		addr = '0;
		wdata = '0;
		wr = 1'b0;
		rd = 1'b0;
		void'($urandom(32'h152990ec));
		for (int i = 0; i < REG_COUNT; i++) m[i] = after_cond(i, 8'h00, 0, '0);
		// Seven edges here and the release edge below make eight cycles in reset
		repeat (7) @(posedge clk);
		@(negedge clk);
		check("core_held", core_held, 1);
		check_image();
		@(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		for (int k = 0; k < 8; k++) begin
			c = k > 6 ? 6 : k;
			for (int a = 0; a < 64; a++) begin
				if (a != 2) begin
					wr_reg(a, 8'($urandom));
					rd_chk(a);
				end
			end
			wr_reg(11, {k == 6, 7'($urandom)});
			d = 8'($urandom);
			wr_reg(2, d);
			wr <= 1'b0;
			wake_src <= 24'($urandom) & 24'h7fffff;
			sleep_pc <= 13'($urandom);
			@(negedge clk);
			check("start_load", start_load, 1);
			check("start_address", start_address, {m[10][4:0], d});
			@(posedge clk);
			// Lowest wake is always raised too, so priority is exercised
			cond <= (7'h40 >> c) | 7'h01;
			wr <= 1'b1;
			addr <= 6'h00;
			wdata <= ~m[0];
			@(posedge clk);
			wr <= 1'b0;
			repeat (2) @(posedge clk);
			for (int i = 0; i < REG_COUNT; i++) m[i] = after_cond(i, m[i], c, wake_src);
			exp_pc = c < 5 ? 13'h0 : (k == 6 ? 13'h0004 : 13'(sleep_pc + 13'h1));
			@(negedge clk);
			check("core_held", core_held, 1);
			check("start_address", start_address, exp_pc);
			check_image();
			@(posedge clk);
			cond <= '0;
			@(posedge clk);
			@(negedge clk);
			check("start_load", start_load, 1);
			check("core_held", core_held, 0);
			@(negedge clk);
			check("start_load", start_load, 0);
			@(posedge clk);
		end
		finish_test();
	end
endmodule
